// File: rtl/cmft_map.vh
// Timing constants and reset values for the conflict monitor fault timing block
`ifndef CMFT_MAP_VH
`define CMFT_MAP_VH
`define CMFT_CLK_HZ 250000000
`define CMFT_TICK_HZ 1000
`define CMFT_TICK_DIV (`CMFT_CLK_HZ / `CMFT_TICK_HZ)
`define CMFT_ABS_EXT_MS 1350
`define CMFT_ABS_LEG_MS 850
`define CMFT_WDT_EXT_MS 1000
`define CMFT_WDT_LEG_MS 1500
`define CMFT_BRN_EXT_MS 400
`define CMFT_BRN_LEG_MS 80
`define CMFT_ZERO18 18'h0_0000
`define CMFT_SYNC_RST 16'h0800
`endif

// File: rtl/cmft_qual.v
// Qualification timer counting timebase ticks while a condition holds
`timescale 1ns/1ps
module cmft_qual #(
   parameter CW = 12
) (
   input wire clk_in,
   input wire reset_in,
   input wire tick_in,
   input wire cond_in,
   input wire [CW-1:0] limit_in,
   output wire expired_out
);
   reg [CW-1:0] cnt_r;
   reg [CW-1:0] cnt_nxt;

   // Count ticks, restart when condition drops
   always @* begin
      cnt_nxt = cnt_r;
      if (!cond_in) begin
         cnt_nxt = {CW{1'b0}};
      end else if (tick_in && (cnt_r < limit_in)) begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_r <= {CW{1'b0}};
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign expired_out = cond_in && (cnt_r >= limit_in);
endmodule // cmft_qual

// File: rtl/cmft_top.v
// Fault supervision and timing selection for an 18-channel conflict monitor
// Notes on behaviour
// R1: Eighteen channels, each green, yellow, red input
// R2: Missing card faults until card present, reset
// R3: Conflict marks active channels; others mark failed (marks kept in mark_r, which drives no output)
// R4: Captured indications held until reset
// R5: 54 channel lamps plus status indicators
// R6: Absent indication extended timing 1350 ms
// R7: Absent indication legacy timing 850 ms
// R8: Watchdog extended timeout 1.0 s
// R9: Watchdog legacy timeout 1.5 s
// R10: Brown-out extended: 400 ms dropout persistence
// R11: Brown-out legacy: 80 ms dropout persistence
// R12: Latch off: power events clear watchdog fault
// R13: Latch on: watchdog fault cleared only by reset
// R14: Fault held until panel or remote reset
// R15: Controller toggles watchdog; no toggle means fault
// R16: Timers count ticks, restart when condition ends
`timescale 1ns/1ps
`include "cmft_map.vh"
module cmft_top #(
   parameter NCH = 18,
   parameter TICK_DIV = `CMFT_TICK_DIV
) (
   input wire CLK_IN,
   input wire RESET_IN,
   input wire [NCH-1:0] GREEN_IN,
   input wire [NCH-1:0] YELLOW_IN,
   input wire [NCH-1:0] RED_IN,
   input wire CONFLICT_IN,
   input wire DUAL_IN,
   input wire CLEARANCE_IN,
   input wire ABSENT_EN_IN,
   input wire CARD_PRESENT_IN,
   input wire DC_FAIL_IN,
   input wire DIAG_FAIL_IN,
   input wire LINE_LOW_IN,
   input wire POWER_EVENT_IN,
   input wire WATCHDOG_IN,
   input wire PANEL_RESET_IN,
   input wire REMOTE_RESET_IN,
   input wire ABS_EXT_SW_IN,
   input wire WDT_EXT_SW_IN,
   input wire BRN_EXT_SW_IN,
   input wire WDT_LATCH_SW_IN,
   output reg [NCH-1:0] CH_GREEN_OUT,
   output reg [NCH-1:0] CH_YELLOW_OUT,
   output reg [NCH-1:0] CH_RED_OUT,
   output reg AC_POWER_OUT,
   output reg DC_SUPPLY_FAIL_INDICATOR_OUT,
   output reg WATCHDOG_TIMEOUT_INDICATOR_OUT,
   output reg CONFLICT_IND_OUT,
   output reg ABSENT_IND_OUT,
   output reg DUAL_IND_OUT,
   output reg CLEARANCE_IND_OUT,
   output reg PROGRAM_CARD_MISSING_INDICATOR_OUT,
   output reg DIAG_FAIL_IND_OUT,
   output reg FAULT_OUT
);
   localparam NI = 16;

   // Two-stage synchronisers; card-present idles high, no false card fault after reset
   reg [NI-1:0] s1_r;
   reg [NI-1:0] s2_r;
   reg [NCH-1:0] g1_r, g2_r, y1_r, y2_r, r1_r, r2_r;
   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         s1_r <= `CMFT_SYNC_RST;
         s2_r <= `CMFT_SYNC_RST;
         g1_r <= `CMFT_ZERO18;
         g2_r <= `CMFT_ZERO18;
         y1_r <= `CMFT_ZERO18;
         y2_r <= `CMFT_ZERO18;
         r1_r <= `CMFT_ZERO18;
         r2_r <= `CMFT_ZERO18;
      end else begin
         s1_r <= {CONFLICT_IN, DUAL_IN, CLEARANCE_IN, ABSENT_EN_IN, CARD_PRESENT_IN,
                  DC_FAIL_IN, DIAG_FAIL_IN, LINE_LOW_IN, POWER_EVENT_IN, WATCHDOG_IN,
                  PANEL_RESET_IN, REMOTE_RESET_IN, ABS_EXT_SW_IN, WDT_EXT_SW_IN,
                  BRN_EXT_SW_IN, WDT_LATCH_SW_IN};
         s2_r <= s1_r;
         g1_r <= GREEN_IN; // see R1
         g2_r <= g1_r;
         y1_r <= YELLOW_IN;
         y2_r <= y1_r;
         r1_r <= RED_IN;
         r2_r <= r1_r;
      end
   end

   wire conflict = s2_r[15];
   wire dual = s2_r[14];
   wire clear_f = s2_r[13];
   wire abs_en = s2_r[12];
   wire card_ok = s2_r[11];
   wire dc_fail = s2_r[10];
   wire diag = s2_r[9];
   wire line_low = s2_r[8];
   wire pwr_evt = s2_r[7];
   wire wdog = s2_r[6];
   wire any_reset = s2_r[5] | s2_r[4];
   wire abs_ext = s2_r[3];
   wire wdt_ext = s2_r[2];
   wire brn_ext = s2_r[1];
   wire wdt_latch = s2_r[0];

   // Millisecond timebase
   reg [27:0] div_r;
   wire tick = (div_r == TICK_DIV - 1);
   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         div_r <= 28'h000_0000;
      end else if (tick) begin
         div_r <= 28'h000_0000;
      end else begin
         div_r <= div_r + 28'h000_0001;
      end
   end

   // Absent indication detection per channel
   wire [NCH-1:0] absent_ch = abs_en ? ~(g2_r | y2_r | r2_r) : `CMFT_ZERO18;
   wire [NCH-1:0] abs_exp;
   wire [11:0] abs_lim = abs_ext ? 12'd`CMFT_ABS_EXT_MS : 12'd`CMFT_ABS_LEG_MS; // see R6 R7
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi = gi + 1) begin : g_abs
         cmft_qual #(.CW(12)) u_abs (
            .clk_in(CLK_IN),
            .reset_in(RESET_IN),
            .tick_in(tick),
            .cond_in(absent_ch[gi]),
            .limit_in(abs_lim),
            .expired_out(abs_exp[gi])
         ); // see R16
      end
   endgenerate

   // Watchdog toggle detection
   reg wd_prev_r;
   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         wd_prev_r <= 1'b0;
      end else begin
         wd_prev_r <= wdog;
      end
   end
   wire wd_quiet = (wdog == wd_prev_r); // see R15
   wire [11:0] wdt_lim = wdt_ext ? 12'd`CMFT_WDT_EXT_MS : 12'd`CMFT_WDT_LEG_MS; // see R8 R9
   wire wdt_exp;
   cmft_qual #(.CW(12)) u_wdt (
      .clk_in(CLK_IN),
      .reset_in(RESET_IN),
      .tick_in(tick),
      .cond_in(wd_quiet),
      .limit_in(wdt_lim),
      .expired_out(wdt_exp)
   );

   // Brown-out persistence (threshold compare done upstream per mode)
   wire [11:0] brn_lim = brn_ext ? 12'd`CMFT_BRN_EXT_MS : 12'd`CMFT_BRN_LEG_MS; // see R10 R11
   wire brn_exp;
   cmft_qual #(.CW(12)) u_brn (
      .clk_in(CLK_IN),
      .reset_in(RESET_IN),
      .tick_in(tick),
      .cond_in(line_low),
      .limit_in(brn_lim),
      .expired_out(brn_exp)
   );

   // Fault latch and captured channel snapshot
   reg trig_r;
   reg card_f_r, conf_f_r, abs_f_r, dual_f_r, clr_f_r, dc_f_r, diag_f_r, wdt_f_r;
   reg [NCH-1:0] mark_r;
   wire new_fault = (!card_ok) | conflict | dual | clear_f | (|abs_exp) | dc_fail | diag
                    | wdt_exp;
   wire rst_ok = any_reset && card_ok && !new_fault; // see R2 R14
   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         trig_r <= 1'b0;
         card_f_r <= 1'b0;
         conf_f_r <= 1'b0;
         abs_f_r <= 1'b0;
         dual_f_r <= 1'b0;
         clr_f_r <= 1'b0;
         dc_f_r <= 1'b0;
         diag_f_r <= 1'b0;
         wdt_f_r <= 1'b0;
         mark_r <= `CMFT_ZERO18;
      end else if (rst_ok) begin
         trig_r <= 1'b0; // see R14
         card_f_r <= 1'b0;
         conf_f_r <= 1'b0;
         abs_f_r <= 1'b0;
         dual_f_r <= 1'b0;
         clr_f_r <= 1'b0;
         dc_f_r <= 1'b0;
         diag_f_r <= 1'b0;
         wdt_f_r <= 1'b0; // see R13
         mark_r <= `CMFT_ZERO18;
      end else if (!trig_r) begin
         trig_r <= new_fault;
         card_f_r <= !card_ok; // see R2
         conf_f_r <= conflict;
         abs_f_r <= |abs_exp;
         dual_f_r <= dual;
         clr_f_r <= clear_f;
         dc_f_r <= dc_fail;
         diag_f_r <= diag;
         wdt_f_r <= wdt_exp;
         // Conflict marks active channels, others failed ones
         mark_r <= conflict ? (g2_r | y2_r) : abs_exp; // see R3
      end else begin
         // Watchdog fault dropped by power events unless latched
         if (wdt_f_r && !wdt_latch && (pwr_evt || brn_exp)) begin
            wdt_f_r <= 1'b0; // see R12
         end
      end
   end

   // Indicator outputs; channel lamps frozen while triggered
   always @(posedge CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         CH_GREEN_OUT <= `CMFT_ZERO18;
         CH_YELLOW_OUT <= `CMFT_ZERO18;
         CH_RED_OUT <= `CMFT_ZERO18;
         AC_POWER_OUT <= 1'b0;
         DC_SUPPLY_FAIL_INDICATOR_OUT <= 1'b0;
         WATCHDOG_TIMEOUT_INDICATOR_OUT <= 1'b0;
         CONFLICT_IND_OUT <= 1'b0;
         ABSENT_IND_OUT <= 1'b0;
         DUAL_IND_OUT <= 1'b0;
         CLEARANCE_IND_OUT <= 1'b0;
         PROGRAM_CARD_MISSING_INDICATOR_OUT <= 1'b0;
         DIAG_FAIL_IND_OUT <= 1'b0;
         FAULT_OUT <= 1'b0;
      end else begin
         if (!trig_r) begin
            CH_GREEN_OUT <= g2_r; // see R4 R5
            CH_YELLOW_OUT <= y2_r;
            CH_RED_OUT <= r2_r;
         end
         AC_POWER_OUT <= !brn_exp;
         DC_SUPPLY_FAIL_INDICATOR_OUT <= dc_f_r;
         WATCHDOG_TIMEOUT_INDICATOR_OUT <= wdt_f_r;
         CONFLICT_IND_OUT <= conf_f_r;
         ABSENT_IND_OUT <= abs_f_r;
         DUAL_IND_OUT <= dual_f_r;
         CLEARANCE_IND_OUT <= clr_f_r;
         PROGRAM_CARD_MISSING_INDICATOR_OUT <= card_f_r;
         DIAG_FAIL_IND_OUT <= diag_f_r;
         FAULT_OUT <= trig_r;
      end
   end
endmodule // cmft_top

// File: tb/cmft_props.sv
// Port-level checks for the fault timing block
`timescale 1ns/1ps
module cmft_props #(
   parameter NCH = 18
) (
   input wire CLK_IN,
   input wire RESET_IN,
   input wire CONFLICT_IN,
   input wire CARD_PRESENT_IN,
   input wire PANEL_RESET_IN,
   input wire REMOTE_RESET_IN,
   input wire [NCH-1:0] CH_GREEN_OUT,
   input wire CONFLICT_IND_OUT,
   input wire PROGRAM_CARD_MISSING_INDICATOR_OUT,
   input wire FAULT_OUT
);
   wire rq = PANEL_RESET_IN | REMOTE_RESET_IN;
   wire pci = PROGRAM_CARD_MISSING_INDICATOR_OUT;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RESET_IN);
   // Trips, holds and clears
   conf_trip_a: assert property (CONFLICT_IN |-> ##[1:6] FAULT_OUT) else $error("no trip");
   card_trip_a: assert property (!CARD_PRESENT_IN |-> ##[1:6] FAULT_OUT) else $error("no trip");
   card_hold_a: assert property ((!CARD_PRESENT_IN)[*5] ##0 FAULT_OUT |=> FAULT_OUT)
      else $error("cleared with card out");
   fault_hold_a: assert property (FAULT_OUT && !rq && !$past(rq) && !$past(rq, 2)
      && !$past(rq, 3) && !$past(rq, 4) |=> FAULT_OUT) else $error("fault dropped");
   flag_fault_a: assert property (CONFLICT_IND_OUT | pci |-> FAULT_OUT) else $error("flag alone");
   lamp_freeze_a: assert property (FAULT_OUT && $past(FAULT_OUT) |-> $stable(CH_GREEN_OUT))
      else $error("lamps moved");
   conf_sticky_a: assert property ($fell(CONFLICT_IND_OUT) |-> !FAULT_OUT) else $error("flag lost");
   card_sticky_a: assert property ($fell(pci) |-> !FAULT_OUT) else $error("flag lost");
   cover property ($rose(FAULT_OUT));
   cover property ($fell(FAULT_OUT));
   cover property ($rose(pci));
endmodule // cmft_props

bind cmft_top cmft_props #(.NCH(NCH)) i_props (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
   .CONFLICT_IN(CONFLICT_IN), .CARD_PRESENT_IN(CARD_PRESENT_IN), .FAULT_OUT(FAULT_OUT),
   .PANEL_RESET_IN(PANEL_RESET_IN), .REMOTE_RESET_IN(REMOTE_RESET_IN),
   .CH_GREEN_OUT(CH_GREEN_OUT), .CONFLICT_IND_OUT(CONFLICT_IND_OUT),
   .PROGRAM_CARD_MISSING_INDICATOR_OUT(PROGRAM_CARD_MISSING_INDICATOR_OUT));

// File: tb/cmft_ctrl_model.sv
// Controller model that toggles the watchdog line while running
`timescale 1ns/1ps
module cmft_ctrl_model #(
   parameter PER = 50
) (
   input wire clk_in,
   input wire run_in,
   output logic wd_out
);
   int cnt = 0;
   logic wd_r = 1'b0;
   assign wd_out = wd_r;
   // Toggle every PER clocks, stand still when stopped
   always @(posedge clk_in) begin
      cnt <= (cnt + 1) % PER;
      if (run_in && cnt == 0) wd_r <= ~wd_r;
   end
endmodule // cmft_ctrl_model

// File: tb/tb.sv
// Self-checking testbench for the fault timing block
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
   localparam TD = 2;
   logic clk, rst = 1, conf = 0, dual = 0, clr = 0, absn = 0, card = 1, dcf = 0, diag = 0;
   logic low = 0, pwr = 0, prst = 0, rrst = 0, asw = 0, wsw = 0, bsw = 0, lsw = 0, run = 1;
   logic [17:0] g = 18'h0_0000, y = 18'h0_0000, r = 18'h0_0000;
   wire [17:0] lg, ly, lr;
   wire wd, ac, dci, wdi, cfi, abi, dui, cli, pci, dgi, flt;
   int n_tests = 0, n_mismatch = 0;
   cmft_ctrl_model i_ctrl (.clk_in(clk), .run_in(run), .wd_out(wd));
   cmft_top #(.TICK_DIV(TD)) i_dut (.CLK_IN(clk), .RESET_IN(rst), .GREEN_IN(g), .YELLOW_IN(y),
      .RED_IN(r), .CONFLICT_IN(conf), .DUAL_IN(dual), .CLEARANCE_IN(clr), .ABSENT_EN_IN(absn),
      .CARD_PRESENT_IN(card), .DC_FAIL_IN(dcf), .DIAG_FAIL_IN(diag), .LINE_LOW_IN(low),
      .POWER_EVENT_IN(pwr), .WATCHDOG_IN(wd), .PANEL_RESET_IN(prst), .REMOTE_RESET_IN(rrst),
      .ABS_EXT_SW_IN(asw), .WDT_EXT_SW_IN(wsw), .BRN_EXT_SW_IN(bsw), .WDT_LATCH_SW_IN(lsw),
      .CH_GREEN_OUT(lg), .CH_YELLOW_OUT(ly), .CH_RED_OUT(lr), .AC_POWER_OUT(ac),
      .DC_SUPPLY_FAIL_INDICATOR_OUT(dci), .WATCHDOG_TIMEOUT_INDICATOR_OUT(wdi),
      .CONFLICT_IND_OUT(cfi), .ABSENT_IND_OUT(abi), .DUAL_IND_OUT(dui), .CLEARANCE_IND_OUT(cli),
      .PROGRAM_CARD_MISSING_INDICATOR_OUT(pci), .DIAG_FAIL_IND_OUT(dgi), .FAULT_OUT(flt));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task cyc(input int n); repeat (n) @(posedge clk); #1; endtask
   task hard_reset; rst = 1'b1; cyc(20); rst = 1'b0; cyc(5); endtask
   // Reset request pulse: panel when rem is 0, remote when rem is 1
   task clear_by(input logic rem); prst = ~rem; rrst = rem; cyc(10); {prst, rrst} = 2'b00; cyc(2);
   endtask
   // Conflict freezes the lamp snapshot until a panel reset
   task t_conflict;
      g = 18'h2_0041; y = 18'h0_0100; r = 18'h1_0002; cyc(10); conf = 1'b1; cyc(8); conf = 1'b0;
      `CHK({flt, cfi, lg, ly}, {2'b11, 18'h2_0041, 18'h0_0100})
      g = 18'h0_0000; r = 18'h0_0000; cyc(10);
      `CHK({lg, lr}, {18'h2_0041, 18'h1_0002})
      clear_by(1'b0);
      `CHK({flt, cfi, lg}, {2'b00, 18'h0_0000})
   endtask
   // Missing card refuses reset until the card returns
   task t_card;
      card = 1'b0; cyc(8);
      `CHK({flt, pci}, 2'b11)
      clear_by(1'b1);
      `CHK(flt, 1'b1)
      card = 1'b1; cyc(8); clear_by(1'b1);
      `CHK({flt, pci}, 2'b00)
   endtask
   // Each plain fault input lights its own indicator
   task t_flags;
      for (int i = 0; i < 4; i++) begin
         {dcf, diag, dual, clr} = 4'b1000 >> i; cyc(8);
         `CHK({flt, dci, dgi, dui, cli}, {1'b1, 4'b1000 >> i})
         {dcf, diag, dual, clr} = 4'h0; clear_by(1'b0);
      end
   endtask
   task cond(input int s, input logic v);
      case (s)
         0: absn = v;
         1: low = v;
         default: run = ~v;
      endcase
   endtask
   function logic mon(input int s);
      return (s == 0) ? abi : (s == 1) ? ~ac : wdi;
   endfunction
   // Timed fault: interrupted run restarts, then expiry inside the tolerance band
   task t_timed(input int s, input logic sw, input int lim, input int tol, input logic la);
      {asw, bsw, wsw, lsw} = {sw, sw, sw, la};
      cond(s, 1'b1); cyc(lim / 2 * TD); cond(s, 1'b0); cyc(120); cond(s, 1'b1);
      cyc((lim - tol) * TD);
      `CHK(mon(s), 1'b0)
      cyc(2 * tol * TD);
      `CHK(mon(s), 1'b1)
      if (s == 2) begin
         pwr = 1'b1; cyc(8); pwr = 1'b0;
         `CHK(wdi, la)
      end
      cond(s, 1'b0); hard_reset;
   endtask
   task finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      hard_reset; t_conflict; t_card; t_flags;
      t_timed(0, 1'b1, 1350, 150, 1'b0); t_timed(0, 1'b0, 850, 150, 1'b0);
      t_timed(1, 1'b1, 400, 50, 1'b0); t_timed(1, 1'b0, 80, 10, 1'b0);
      t_timed(2, 1'b1, 1000, 100, 1'b0); t_timed(2, 1'b0, 1500, 100, 1'b1);
      finish_test;
   end
   initial begin
      #150000; n_mismatch++; finish_test;
   end
endmodule // tb
